//--- serial_ctrl_pkg.sv
/*
 * Shared constants for the serial control-register controller: software register map,
 * status bits, opcodes, packet shape and serial clock timing.
 * Assumes a 125 MHz system clock and one controller driving every device on the chain.
 */
package serial_ctrl_pkg;

    // ======================================================================
    // software register map (byte offsets, 32-bit words)
    localparam logic [7:0] OFF_REQ_FIELDS = 8'h00; // opcode, broadcast, device number
    localparam logic [7:0] OFF_REG_ADDR = 8'h04;   // register address
    localparam logic [7:0] OFF_WR_DATA = 8'h08;    // data for a register write
    localparam logic [7:0] OFF_LAUNCH = 8'h0C;     // write-only start strobes
    localparam logic [7:0] OFF_STATUS = 8'h10;     // state flags, refused is write-one-clear
    localparam logic [7:0] OFF_RD_DATA = 8'h14;    // last data returned by a read
    localparam logic [7:0] OFF_RESET_GAP = 8'h18;  // set-to-clear gap in serial periods

    // ======================================================================
    // field positions
    localparam int OP_LSB = 0;
    localparam int BCAST_BIT = 4;
    localparam int DEV_LSB = 8;
    localparam int LAUNCH_CMD_BIT = 0;
    localparam int LAUNCH_PRST_BIT = 1;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_PORT_DONE_BIT = 1;
    localparam int ST_T77_DONE_BIT = 2;
    localparam int ST_RST_PEND_BIT = 3;
    localparam int ST_REFUSED_BIT = 4;

    // ======================================================================
    // opcodes of the request packet
    localparam logic [3:0] OP_READ = 4'h0;
    localparam logic [3:0] OP_WRITE = 4'h1;
    localparam logic [3:0] OP_SET_RESET = 4'h2;
    localparam logic [3:0] OP_FAST_CLOCK = 4'h4;
    localparam logic [3:0] OP_CLEAR_RESET = 4'hB;
    localparam logic [3:0] OP_NOP = 4'hF;

    // ======================================================================
    // device register used by the post-reset sequence (address is a plain default)
    localparam logic [11:0] TEST_77_REGISTER_ADDR = 12'h000;

    // ======================================================================
    // packet shape and timing, counts in serial clock periods unless noted
    localparam logic [3:0] LAST_CYC = 4'hF;        // 16 serial cycles per packet
    localparam logic [3:0] FRAME_HI_CYC = 4'h2;    // 11110000 over both edges = 2 high cycles
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCK_PERIOD_NS = 128;
    localparam logic [7:0] SCK_HALF_CLKS = 8'((SCK_PERIOD_NS / CLK_PERIOD_NS) / 2);
    localparam logic [4:0] PRST_SCK = 5'h10;       // length of the port reset frame
    localparam logic [15:0] SET_GAP_MIN_SCK = 16'h0010;
    localparam logic [15:0] POST_CMD_SCK = 16'h0004;
    localparam logic [15:0] RESET_GAP_RST = 16'h0010;

endpackage : serial_ctrl_pkg

//--- sck_if.sv
/*
 * Carrier between the controller core and its serial clock generator.
 * Assumes both ends share clk; rise is a one-cycle pulse.
 */
`timescale 1ns/1ns
interface sck_if;
    logic run;
    logic sck;
    logic rise;
    modport gen (input run, output sck, output rise);
    modport user (output run, input sck, input rise);
endinterface : sck_if

//--- sck_gen.sv
/*
 * Serial clock divider: produces the serial clock and a pulse at each rising edge.
 * Assumes run is driven on clk; once run drops the current high half is finished first.
 */
`timescale 1ns/1ns
module sck_gen (
    input wire logic clk,
    input wire logic rst_n,
    sck_if.gen link
);
    import serial_ctrl_pkg::*;

    logic [7:0] half_cnt;

    // ======================================================================
    // divider
    wire active = link.run || link.sck;  // never cut a high half short
    wire half_end = active && (half_cnt == SCK_HALF_CLKS - 8'h01);

    // half-period counter and clock level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            half_cnt <= 8'h00;
            link.sck <= 1'b0;
            link.rise <= 1'b0;
        end else begin
            half_cnt <= (!active || half_end) ? 8'h00 : half_cnt + 8'h01;
            link.sck <= half_end ? !link.sck : (active && link.sck);
            link.rise <= half_end && !link.sck && link.run;
        end
    end

endmodule : sck_gen

//--- serial_ctrl_reg_port.sv
/*
 * Controller for the serial control-register port of a chain of memory devices:
 * frames request, address, data and interval packets and takes back read data.
 * Assumes the devices share sck and cmd, the first device's chain pin meets chain_*,
 * and software reaches the controller over a simple strobe port.
 */
// Implementation choices: the address map and the address-and-strobe port.
//
// Function
// - reserved request and address packet bits are always sent as zero
// - set-reset is followed by at least 16 serial periods before clear-reset
// - fast-clock command is followed by at least 4 idle serial periods
// - clear-reset command is followed by at least 4 idle serial periods
// - reserved opcodes are never sent; launching one is refused
// - data packet is sixteen bits, most significant first, both directions
// - set-reset and clear-reset go as a pair, nothing between except a port reset, which drops the pending clear-reset
// - gap between the pair is the larger of 16 and the programmed gap
// - port reset precedes every register transaction
// - serial clock stays low until port reset is performed
// - test register 77 is written with zeros before any other register access
// - software writes the channel clock cycle time in 64 ps units
// - software gives serial identities 0 to 31 by chain distance, nearest 0
// - software gives channel identities 0 to 31, independent of serial ones
// - request packet is framed by 11110000 on cmd, sampled on both edges
// - bits change at the rise for the falling sample; read data sampled at the rise
// - write: request, address, data, interval; read: request, address, interval, data
// - reset and fast-clock commands are one request packet with the same framing
`timescale 1ns/1ns
module serial_ctrl_reg_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic sck,
    output logic cmd,
    input wire logic chain_in,
    output logic chain_out,
    output logic chain_oe
);
    import serial_ctrl_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE, ST_PRST, ST_REQ, ST_ADR, ST_DAT, ST_INT, ST_RDAT, ST_TAIL, ST_WAIT
    } state_t;

    state_t state;
    state_t next_state;
    logic [3:0] cyc;
    logic [15:0] wait_cnt;
    logic [15:0] next_wait;
    logic [3:0] opcode_field;
    logic broadcast_bit;
    logic [5:0] device_number;
    logic [11:0] register_address;
    logic [15:0] data_bits;
    logic [15:0] reset_gap;
    logic [15:0] read_back;
    logic [15:0] rd_shift;
    logic [15:0] req_word;
    logic [15:0] adr_word;
    logic [15:0] dat_word;
    logic [3:0] run_op;
    logic port_done;
    logic test_77_register_done;
    logic reset_pending;
    logic refused;
    logic chain_s1;
    logic chain_s2;

    sck_if link ();

    sck_gen u_sck_gen (
        .clk(clk),
        .rst_n(rst_n),
        .link(link)
    );

    // ======================================================================
    // helpers
    function automatic logic is_reserved_op(input logic [3:0] op);
        is_reserved_op = !(op == OP_READ || op == OP_WRITE || op == OP_SET_RESET ||
                           op == OP_FAST_CLOCK || op == OP_CLEAR_RESET || op == OP_NOP);
    endfunction : is_reserved_op

    function automatic logic is_reg_op(input logic [3:0] op);
        is_reg_op = (op == OP_READ) || (op == OP_WRITE);
    endfunction : is_reg_op

    // serial gap after a single-packet command, at least one period so the last fall completes
    function automatic logic [15:0] post_gap(input logic [3:0] op, input logic [15:0] gap);
        if (op == OP_SET_RESET) begin
            post_gap = (gap > SET_GAP_MIN_SCK) ? gap : SET_GAP_MIN_SCK;
        end else if (op == OP_FAST_CLOCK || op == OP_CLEAR_RESET) begin
            post_gap = POST_CMD_SCK;
        end else begin
            post_gap = 16'h0001;
        end
    endfunction : post_gap

    // ======================================================================
    // chain pin synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chain_s1 <= 1'b0;
            chain_s2 <= 1'b0;
        end else begin
            chain_s1 <= chain_in;
            chain_s2 <= chain_s1;
        end
    end

    // ======================================================================
    // software port decode
    wire idle = (state == ST_IDLE);
    wire wr_launch = wr && (addr == OFF_LAUNCH);
    wire go_prst = wr_launch && wdata[LAUNCH_PRST_BIT];
    wire go_cmd = wr_launch && wdata[LAUNCH_CMD_BIT] && !wdata[LAUNCH_PRST_BIT];
    wire t77_write = (opcode_field == OP_WRITE) && (register_address == TEST_77_REGISTER_ADDR) &&
                     (data_bits == 16'h0000);
    wire t77_block = is_reg_op(opcode_field) && !test_77_register_done && !t77_write;
    wire pair_block = reset_pending ? (opcode_field != OP_CLEAR_RESET)
                                    : (opcode_field == OP_CLEAR_RESET);
    wire cmd_bad = !idle || is_reserved_op(opcode_field) || !port_done ||
                   t77_block || pair_block;
    wire accept_cmd = go_cmd && !cmd_bad;
    wire accept_prst = go_prst && idle;
    wire refuse_now = (go_cmd && cmd_bad) || (go_prst && !idle);
    wire clr_refused = wr && (addr == OFF_STATUS) && wdata[ST_REFUSED_BIT];
    wire [31:0] status_word = {27'h0000000, refused, reset_pending, test_77_register_done, port_done,
                               !idle};

    // field registers, the reset gap and the refused flag (a new refusal beats its clear)
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opcode_field <= OP_NOP;
            broadcast_bit <= 1'b0;
            device_number <= 6'h00;
            register_address <= 12'h000;
            data_bits <= 16'h0000;
            reset_gap <= RESET_GAP_RST;
            refused <= 1'b0;
        end else begin
            if (wr && addr == OFF_REQ_FIELDS) begin
                opcode_field <= wdata[OP_LSB +: 4];
                broadcast_bit <= wdata[BCAST_BIT];
                device_number <= wdata[DEV_LSB +: 6];
            end
            if (wr && addr == OFF_REG_ADDR) begin
                register_address <= wdata[11:0];
            end
            if (wr && addr == OFF_WR_DATA) begin
                data_bits <= wdata[15:0];
            end
            if (wr && addr == OFF_RESET_GAP) begin
                reset_gap <= wdata[15:0];
            end
            refused <= refuse_now || (refused && !clr_refused);
        end
    end

    // read data stands only in the cycle after the read strobe
    wire [31:0] rd_mux = (addr == OFF_REQ_FIELDS) ? {18'h00000, device_number, 3'h0,
                                                     broadcast_bit, opcode_field} :
                         (addr == OFF_REG_ADDR) ? {20'h00000, register_address} :
                         (addr == OFF_WR_DATA) ? {16'h0000, data_bits} :
                         (addr == OFF_STATUS) ? status_word :
                         (addr == OFF_RD_DATA) ? {16'h0000, read_back} :
                         (addr == OFF_RESET_GAP) ? {16'h0000, reset_gap} : 32'h00000000;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= rd ? rd_mux : 32'h00000000;
        end
    end

    // ======================================================================
    // packet words latched at launch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_word <= 16'h0000;
            adr_word <= 16'h0000;
            dat_word <= 16'h0000;
            run_op <= OP_NOP;
        end else if (accept_cmd) begin
            req_word <= {5'h00, device_number[5], opcode_field, broadcast_bit,
                         device_number[4:0]};
            adr_word <= {4'h0, register_address};
            dat_word <= data_bits;
            run_op <= opcode_field;
        end
    end

    // ======================================================================
    // sequencer: one step per serial rise
    wire last = (cyc == LAST_CYC);
    wire prst_last = ({1'b0, cyc} == PRST_SCK - 5'h01);
    wire [15:0] single_gap = post_gap(run_op, reset_gap);

    always_comb begin
        next_state = state;
        next_wait = wait_cnt;
        case (state)
            ST_IDLE: begin
                if (accept_prst) begin
                    next_state = ST_PRST;
                end else if (accept_cmd) begin
                    next_state = ST_REQ;
                end
            end
            ST_PRST: begin
                if (prst_last) begin
                    next_state = ST_IDLE;
                end
            end
            ST_REQ: begin
                if (last && is_reg_op(run_op)) begin
                    next_state = ST_ADR;
                end else if (last) begin
                    next_state = ST_WAIT;
                    next_wait = single_gap;
                end
            end
            ST_ADR: begin
                if (last) begin
                    next_state = (run_op == OP_WRITE) ? ST_DAT : ST_INT;
                end
            end
            ST_DAT: begin
                if (last) begin
                    next_state = ST_INT;
                end
            end
            ST_INT: begin
                if (last) begin
                    next_state = (run_op == OP_READ) ? ST_RDAT : ST_IDLE;
                end
            end
            ST_RDAT: begin
                if (last) begin
                    next_state = ST_TAIL;
                end
            end
            ST_TAIL: begin
                next_state = ST_IDLE;
            end
            ST_WAIT: begin
                if (wait_cnt <= 16'h0001) begin
                    next_state = ST_IDLE;
                end else begin
                    next_wait = wait_cnt - 16'h0001;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // launches move on clk, packet steps only on a serial rise
    wire step = idle || link.rise;
    assign link.run = !idle;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cyc <= 4'h0;
            wait_cnt <= 16'h0000;
        end else if (step) begin
            state <= next_state;
            wait_cnt <= next_wait;
            cyc <= (idle || next_state != state) ? 4'h0 : cyc + 4'h1;
        end
    end

    // ======================================================================
    // pin drive, updated at each rise so bits are steady at the falling sample
    wire [15:0] cur_word = (state == ST_REQ) ? req_word :
                           (state == ST_ADR) ? adr_word :
                           (state == ST_DAT) ? dat_word : 16'h0000;
    wire cur_bit = cur_word[LAST_CYC - cyc];
    wire drive = (state == ST_PRST) || (state == ST_REQ) || (state == ST_ADR) ||
                 (state == ST_DAT) || (state == ST_INT);
    wire frame = ((state == ST_REQ) && (cyc < FRAME_HI_CYC)) || (state == ST_PRST);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd <= 1'b0;
            chain_out <= 1'b0;
            chain_oe <= 1'b0;
        end else if (link.rise) begin
            cmd <= frame;
            chain_out <= drive && cur_bit;
            chain_oe <= drive;
        end else if (idle) begin
            cmd <= 1'b0;
            chain_out <= 1'b0;
            chain_oe <= 1'b0;
        end
    end

    assign sck = link.sck;

    // ======================================================================
    // read data: bit n is driven at a fall and taken at the following rise
    wire take = link.rise && (((state == ST_RDAT) && (cyc != 4'h0)) || (state == ST_TAIL));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_shift <= 16'h0000;
            read_back <= 16'h0000;
        end else if (take) begin
            rd_shift <= {rd_shift[14:0], chain_s2};
            if (state == ST_TAIL) begin
                read_back <= {rd_shift[14:0], chain_s2};
            end
        end
    end

    // ======================================================================
    // sequencing flags: port reset, test register, set/clear pairing
    wire prst_end = link.rise && (state == ST_PRST) && prst_last;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_done <= 1'b0;
            test_77_register_done <= 1'b0;
            reset_pending <= 1'b0;
        end else if (prst_end) begin
            port_done <= 1'b1;
            test_77_register_done <= 1'b0;
            reset_pending <= 1'b0;
        end else if (accept_cmd) begin
            test_77_register_done <= test_77_register_done || t77_write;
            reset_pending <= (opcode_field == OP_SET_RESET);
        end
    end

endmodule : serial_ctrl_reg_port

//--- serial_ctrl_reg_port_chk.sv
/* checker: port-level timing of the serial register controller.
   assumes one clock domain, clk with async active-low rst_n. */
`timescale 1ns/1ns
module serial_ctrl_reg_port_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic sck,
    input wire logic cmd,
    input wire logic chain_in,
    input wire logic chain_out,
    input wire logic chain_oe
);
    import serial_ctrl_pkg::*;
    logic prst_seen;
    logic [9:0] hi_cnt;
    // remember a port reset request; count cycles cmd stays high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prst_seen <= 1'b0;
            hi_cnt <= 10'h000;
        end else begin
            if (wr && addr == OFF_LAUNCH && wdata[LAUNCH_PRST_BIT]) prst_seen <= 1'b1;
            hi_cnt <= cmd ? hi_cnt + 10'h001 : 10'h000;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sck_held_a: assert property (!prst_seen |-> !sck)
        else $error("serial clock moved before port reset");
    sck_high_a: assert property ($rose(sck) |-> sck[*8] ##1 !sck)
        else $error("serial clock high half wrong");
    sck_low_a: assert property ($fell(sck) |-> !sck[*8])
        else $error("serial clock low half too short");
    bit_timing_a: assert property ($changed(chain_out) |-> sck && !$past(sck, 2))
        else $error("chain bit changed away from serial rise");
    frame_start_a: assert property ($rose(cmd) |-> chain_oe && !chain_out)
        else $error("frame start without driven zero bit");
    frame_len_a: assert property ($fell(cmd) |-> hi_cnt == 10'h020 || hi_cnt > 10'h0C8)
        else $error("request framing length wrong");
    rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data outside its cycle");
    status_rsv_a: assert property ($past(rd) && $past(addr) == OFF_STATUS |-> rdata[31:5] == 0)
        else $error("status upper bits not zero");
    unmapped_rd_a: assert property ($past(rd) && $past(addr) > OFF_RESET_GAP |-> rdata == 0)
        else $error("unmapped read not zero");
    cover property ($rose(cmd));
    cover property ($fell(chain_oe) && sck);
    cover property ($past(rd) && $past(addr) == OFF_STATUS && rdata[ST_REFUSED_BIT]);
endmodule : serial_ctrl_reg_port_chk

bind serial_ctrl_reg_port serial_ctrl_reg_port_chk chk_u (.clk(clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sck(sck), .cmd(cmd),
    .chain_in(chain_in), .chain_out(chain_out), .chain_oe(chain_oe));

//--- chain_device_model.sv
/* model of one chain device behind the serial port.
   assumes the bench resolves the chain pin with a pull-up. */
`timescale 1ns/1ns
module chain_device_model #(
    parameter logic [11:0] INIT_ADDR = 12'h021
) (
    input wire logic sck,
    input wire logic cmd,
    input wire logic pin,
    output logic drv_en,
    output logic drv_val
);
    import serial_ctrl_pkg::*;
    logic [15:0] regs [16];
    logic [15:0] sh, rdv;
    logic [5:0] ident;
    logic [3:0] op;
    logic [11:0] ra;
    logic sel;
    int pk = -1;
    int cyc = 0;
    initial drv_en = 1'b0;
    initial drv_val = 1'b0;
    // port reset ends when cmd drops after a long high frame
    always @(negedge cmd) begin
        if (pk == 9) begin
            regs = '{default: 16'h0};
            ident = 6'h3F;
            pk = -1;
        end
    end
    // bits taken at the falling serial edge, read data driven there too
    always @(negedge sck) begin
        if (pk < 0 && cmd) begin
            pk = 0;
            cyc = 0;
        end
        if (pk == 0 && cyc == 2 && cmd) pk = 9;
        if (pk == 5) begin
            drv_en = sel;
            drv_val = rdv[15 - cyc];
        end
        if (pk >= 0 && pk != 9) begin
            sh = {sh[14:0], pin};
            cyc++;
        end
        if (cyc == 16) begin
            cyc = 0;
            case (pk)
                0: begin
                    op = sh[9:6];
                    sel = sh[5] || {sh[10], sh[4:0]} == ident;
                    pk = (op == OP_READ || op == OP_WRITE) ? 1 : -1;
                    if (sel && op == OP_SET_RESET) regs = '{default: 16'h0};
                end
                1: begin
                    ra = sh[11:0];
                    pk = (op == OP_WRITE) ? 2 : 3;
                end
                2: begin
                    if (sel && ra == INIT_ADDR) ident = sh[5:0];
                    else if (sel) regs[ra[3:0]] = sh;
                    pk = 4;
                end
                3: begin
                    rdv = (ra == INIT_ADDR) ? {10'h0, ident} : regs[ra[3:0]];
                    pk = 5;
                end
                5: begin
                    pk = -1;
                    #120 drv_en = 1'b0;
                end
                default: pk = -1;
            endcase
        end
    end
endmodule : chain_device_model

//--- testbench.sv
/* bench: drives the software port and watches the device model's answers.
   assumes one device on the chain and a pull-up on the chain pin. */
`timescale 1ns/1ns
module testbench;
    import serial_ctrl_pkg::*;
    logic clk = 1'b0;
    logic rst_n, wr, rd, sck, cmd, chain_out, chain_oe, drv_en, drv_val;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, v;
    wire chain_pin;
    int num_errors, compares, cycles, n;
    // chain pin: controller, else device, else pull-up
    assign chain_pin = chain_oe ? chain_out : (drv_en ? drv_val : 1'b1);
    serial_ctrl_reg_port dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .sck(sck), .cmd(cmd), .chain_in(chain_pin),
        .chain_out(chain_out), .chain_oe(chain_oe));
    chain_device_model dev_u (.sck(sck), .cmd(cmd), .pin(chain_pin), .drv_en(drv_en),
        .drv_val(drv_val));
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            results();
        end
    end
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic put(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : put
    task automatic get(logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : get
    // poll busy; n holds cycles spent
    task automatic idle;
        n = 0;
        do begin
            get(OFF_STATUS);
            n += 2;
        end while (v[ST_BUSY_BIT] !== 1'b0 && n < 9000);
        // a transaction that never ends is a mismatch and closes the run
        if (v[ST_BUSY_BIT] !== 1'b0) begin
            num_errors++;
            results();
        end
    endtask : idle
    task automatic go(logic [3:0] op, logic bc, logic [5:0] dev, logic [11:0] ra = 0,
            logic [15:0] d = 0);
        put(OFF_REQ_FIELDS, {18'h0, dev, 3'h0, bc, op});
        put(OFF_REG_ADDR, {20'h0, ra});
        put(OFF_WR_DATA, {16'h0, d});
        put(OFF_LAUNCH, 32'h1);
        idle();
    endtask : go
    task automatic refused(logic exp);
        get(OFF_STATUS);
        check("refused flag", v[ST_REFUSED_BIT], exp);
        put(OFF_STATUS, 32'h10);
    endtask : refused
    task automatic t_start;
        get(OFF_REQ_FIELDS);
        check("fields reset", v, 32'hF);
        get(OFF_RESET_GAP);
        check("gap reset", v, 32'h10);
        get(8'h1C);
        check("unmapped read", v, 32'h0);
        go(OP_NOP, 1'b1, 6'h0);
        refused(1'b1);
        check("sck idle", sck, 1'b0);
        put(OFF_LAUNCH, 32'h2);
        idle();
        get(OFF_STATUS);
        check("port reset status", v[3:0], 4'h2);
        go(OP_READ, 1'b1, 6'h0, 12'h5A3);
        refused(1'b1);
        go(OP_WRITE, 1'b1, 6'h0, TEST_77_REGISTER_ADDR);
        refused(1'b0);
        $display("test start done");
    endtask : t_start
    task automatic t_access;
        // busy ends two clocks after the last serial rise: 16 clocks a period, 8 of slack
        go(OP_WRITE, 1'b1, 6'h0, 12'h5A3, 16'hA5C3);
        check("write length", n >= 1016, 1);
        go(OP_READ, 1'b1, 6'h0, 12'h5A3);
        get(OFF_RD_DATA);
        check("read back", v, 32'hA5C3);
        go(OP_WRITE, 1'b1, 6'h0, 12'h021, 16'h5);
        go(OP_READ, 1'b0, 6'h5, 12'h5A3);
        get(OFF_RD_DATA);
        check("selected read", v, 32'hA5C3);
        go(OP_WRITE, 1'b0, 6'h25, 12'h5A3, 16'h1234);
        go(OP_READ, 1'b0, 6'h5, 12'h5A3);
        get(OFF_RD_DATA);
        check("other device write", v, 32'hA5C3);
        go(OP_READ, 1'b0, 6'h6, 12'h5A3);
        get(OFF_RD_DATA);
        check("unselected read", v, 32'hFFFF);
        for (int op = 0; op < 16; op++) begin
            if (op inside {3, [5:10], [12:14]}) begin
                go(4'(op), 1'b1, 6'h0);
                refused(1'b1);
            end
        end
        $display("test access done");
    endtask : t_access
    task automatic t_modes;
        put(OFF_RESET_GAP, 32'h28);
        go(OP_SET_RESET, 1'b1, 6'h0);
        check("set gap", n >= 888, 1);
        get(OFF_STATUS);
        check("pending", v[ST_RST_PEND_BIT], 1'b1);
        go(OP_NOP, 1'b1, 6'h0);
        refused(1'b1);
        go(OP_CLEAR_RESET, 1'b1, 6'h0);
        check("clear wait", n >= 312, 1);
        refused(1'b0);
        go(OP_CLEAR_RESET, 1'b1, 6'h0);
        refused(1'b1);
        go(OP_WRITE, 1'b1, 6'h0, TEST_77_REGISTER_ADDR);
        go(OP_READ, 1'b1, 6'h0, 12'h5A3);
        get(OFF_RD_DATA);
        check("after reset pair", v, 32'h0);
        go(OP_FAST_CLOCK, 1'b1, 6'h0);
        check("fast wait", n >= 312, 1);
        go(OP_NOP, 1'b1, 6'h0);
        check("nop length", n >= 264, 1);
        refused(1'b0);
        $display("test modes done");
    endtask : t_modes
    task automatic results;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results
    initial begin
        rst_n = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_start();
        t_access();
        t_modes();
        results();
    end
endmodule : testbench
